//--- iwdt_pkg.sv
package iwdt_pkg;

  // Counter and prescaler widths
  localparam int CNT_W = 8;
  localparam int PRE_W = 12;
  localparam int MODE_W = 4;
  localparam int SEL_W = 2;

  // Interval mode register fields
  localparam int SEL_MSB = 2;
  localparam int SEL_LSB = 0;
  localparam int CLR_BIT = 3;
  localparam logic [MODE_W-1:0] MODE_RESET = 4'h0;

  // Counter limits
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;

  // Tap index per interval, as a prescaler bit count (period 2**tap clocks)
  localparam logic [SEL_W-1:0] TAP_IDX_LONG = 2'h0;
  localparam logic [SEL_W-1:0] TAP_IDX_MID1 = 2'h1;
  localparam logic [SEL_W-1:0] TAP_IDX_MID2 = 2'h2;
  localparam logic [SEL_W-1:0] TAP_IDX_SHORT = 2'h3;
  localparam int TAP_LONG = 12;
  localparam int TAP_MID1 = 9;
  localparam int TAP_MID2 = 7;
  localparam int TAP_SHORT = 5;

  // Build-time choice of the wait after chip reset
  localparam logic [SEL_W-1:0] RESET_WAIT_SEL_DEF = 2'h0;

  // Sequencing of the stabilisation waits
  typedef enum logic [1:0] {
    ST_RESET_WAIT,
    ST_RUN,
    ST_STOP,
    ST_STOP_WAIT
  } iwdt_state_t;

endpackage

//--- iwdt_tick_if.sv
`timescale 1ns/1ps
interface iwdt_tick_if;
  logic [1:0] tapSel;
  logic tick;
  // Timer side selects the tap and consumes the tick
  modport ctrl (output tapSel, input tick);
  // Prescaler side
  modport gen (input tapSel, output tick);
endinterface

//--- iwdt_prescaler.sv
`timescale 1ns/1ps
module iwdt_prescaler
  import iwdt_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Tap select and tick
  iwdt_tick_if.gen tk
);

  logic [PRE_W-1:0] preReg;
  logic tickReg;

  // Mask of prescaler bits below the selected tap
  function automatic logic [PRE_W-1:0] tapMask(input logic [SEL_W-1:0] sel);
    logic [PRE_W-1:0] m;
    m = '0;
    unique case (sel)
      TAP_IDX_LONG: m = PRE_W'((1 << TAP_LONG) - 1);
      TAP_IDX_MID1: m = PRE_W'((1 << TAP_MID1) - 1);
      TAP_IDX_MID2: m = PRE_W'((1 << TAP_MID2) - 1);
      TAP_IDX_SHORT: m = PRE_W'((1 << TAP_SHORT) - 1);
    endcase
    return m;
  endfunction

  // Free-running chain; nothing but reset stops it
  always_ff @(posedge mclk) begin
    if (rst) begin
      preReg <= '0;
    end else begin
      preReg <= preReg + PRE_W'(1);
    end
  end

  // One tick per full period of the selected tap
  always_ff @(posedge mclk) begin
    if (rst) begin
      tickReg <= 1'b0;
    end else begin
      tickReg <= ((preReg & tapMask(tk.tapSel)) == tapMask(tk.tapSel));
    end
  end

  assign tk.tick = tickReg;

  // Tick always follows an all-ones tap pattern
  property p_tick_tap;
    @(posedge mclk) disable iff (rst)
      tk.tick |-> ($past(preReg & tapMask(tk.tapSel)) == $past(tapMask(tk.tapSel)));
  endproperty
  a_tick_tap: assert property (p_tick_tap) else $error("tick without tap match");

  // Shortest tap still never ticks twice in a row
  property p_tick_gap;
    @(posedge mclk) disable iff (rst)
      tk.tick |=> !tk.tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("back to back ticks");

endmodule // iwdt_prescaler

//--- iwdt_interval_watchdog.sv
`timescale 1ns/1ps
module iwdt_interval_watchdog #(
  parameter logic [1:0] RESET_WAIT_SEL = iwdt_pkg::RESET_WAIT_SEL_DEF
) (
  // Clock and chip reset
  input wire logic mclk,
  input wire logic rst,
  // Mode register write port
  input wire logic modeWrite,
  input wire logic [iwdt_pkg::MODE_W-1:0] modeWrData,
  // Watchdog select and interrupt acknowledge
  input wire logic wdSelectSet,
  input wire logic irqFlagClear,
  // Standby control
  input wire logic stopEnter,
  input wire logic stopRelease,
  // Status read-back
  output logic [iwdt_pkg::MODE_W-1:0] modeValue,
  output logic [iwdt_pkg::CNT_W-1:0] counterValue,
  output logic watchdogSelect,
  output logic irqFlag,
  // Reset and halt to the CPU
  output logic internalReset,
  output logic cpuHalt
);
  import iwdt_pkg::*;

  iwdt_tick_if tk ();

  logic [MODE_W-1:0] modeReg;
  logic [CNT_W-1:0] counterReg;
  logic lockReg;
  logic irqReg;
  logic intResetReg;
  logic haltReg;
  iwdt_state_t stateReg;
  iwdt_state_t stateNext;
  logic localRst;
  logic clearStrobe;
  logic overflow;
  logic startWait;
  logic inRun;

  // Interval field to tap index; each odd code shares the tap of the even code below it
  function automatic logic [SEL_W-1:0] selDecode(input logic [MODE_W-1:0] mode);
    return mode[SEL_MSB:SEL_LSB+1];
  endfunction

  // Watchdog reset re-initialises the timer registers like the chip reset; only chip reset clears the prescaler
  assign localRst = rst || intResetReg;
  assign clearStrobe = modeWrite && modeWrData[CLR_BIT];
  assign overflow = tk.tick && (counterReg == CNT_MAX);
  assign startWait = (stateReg == ST_STOP) && stopRelease;
  assign inRun = (stateReg == ST_RUN);

  // Reset wait ignores the mode register, all else follows it
  assign tk.tapSel = (stateReg == ST_RESET_WAIT) ? RESET_WAIT_SEL : selDecode(modeReg);

  iwdt_prescaler u_prescaler (
    .mclk(mclk),
    .rst(rst),
    .tk(tk)
  );

  // Mode register; clear bit is never stored
  always_ff @(posedge mclk) begin
    if (localRst) begin
      modeReg <= MODE_RESET;
    end else if (modeWrite) begin
      modeReg <= {1'b0, modeWrData[SEL_MSB:SEL_LSB]};
    end
  end

  // Interval counter; no write path exists, only clear and count
  always_ff @(posedge mclk) begin
    if (localRst) begin
      counterReg <= CNT_ZERO;
    end else if (clearStrobe || startWait) begin
      counterReg <= CNT_ZERO;
    end else if (tk.tick) begin
      counterReg <= counterReg + CNT_W'(1);
    end
  end

  // Lock bit: set only, cleared by reset alone
  always_ff @(posedge mclk) begin
    if (localRst) begin
      lockReg <= 1'b0;
    end else if (wdSelectSet) begin
      lockReg <= 1'b1;
    end
  end

  // Interrupt flag; a same-cycle overflow beats either clear
  always_ff @(posedge mclk) begin
    if (localRst) begin
      irqReg <= 1'b0;
    end else if (overflow && !lockReg && inRun) begin
      irqReg <= 1'b1;
    end else if (clearStrobe || irqFlagClear) begin
      irqReg <= 1'b0;
    end
  end

  // One-cycle CPU reset; the wait states mask it
  always_ff @(posedge mclk) begin
    if (rst) begin
      intResetReg <= 1'b0;
    end else begin
      intResetReg <= overflow && lockReg && inRun && !intResetReg;
    end
  end

  // Standby sequencing
  always_comb begin
    stateNext = stateReg;
    unique case (stateReg)
      ST_RESET_WAIT: begin
        if (overflow) begin
          stateNext = ST_RUN;
        end
      end
      ST_RUN: begin
        if (stopEnter) begin
          stateNext = ST_STOP;
        end
      end
      ST_STOP: begin
        if (stopRelease) begin
          stateNext = ST_STOP_WAIT;
        end
      end
      ST_STOP_WAIT: begin
        if (overflow && !startWait) begin
          stateNext = ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (localRst) begin
      stateReg <= ST_RESET_WAIT;
    end else begin
      stateReg <= stateNext;
    end
  end

  // CPU held in stop and through both waits
  always_ff @(posedge mclk) begin
    if (localRst) begin
      haltReg <= 1'b1;
    end else begin
      haltReg <= (stateNext != ST_RUN);
    end
  end

  // Outputs straight from flip-flops
  assign modeValue = modeReg;
  assign counterValue = counterReg;
  assign watchdogSelect = lockReg;
  assign irqFlag = irqReg;
  assign internalReset = intResetReg;
  assign cpuHalt = haltReg;

  // Reset leaves the lock clear
  property p_lock_reset;
    @(posedge mclk) rst |=> !watchdogSelect;
  endproperty
  a_lock_reset: assert property (p_lock_reset) else $error("lock survived reset");

  // Interval-mode overflow raises the flag
  property p_irq_set;
    @(posedge mclk) disable iff (localRst)
      overflow && !lockReg && inRun |=> irqFlag && !internalReset;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("overflow did not set flag");

  // Each tick advances the counter by one
  property p_count;
    @(posedge mclk) disable iff (localRst)
      tk.tick && !clearStrobe && !startWait |=> counterValue == CNT_W'($past(counterValue) + CNT_W'(1));
  endproperty
  a_count: assert property (p_count) else $error("counter did not advance");

  // Without tick or clear the count holds
  property p_hold;
    @(posedge mclk) disable iff (localRst)
      !tk.tick && !clearStrobe && !startWait |=> $stable(counterValue);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved unexpectedly");

  // Clear strobe zeroes counter and flag unless an overflow coincides
  property p_clear;
    @(posedge mclk) disable iff (localRst)
      clearStrobe && !overflow |=> counterValue == CNT_ZERO && !irqFlag;
  endproperty
  a_clear: assert property (p_clear) else $error("clear strobe ignored");

  // Mode write loads the field and never stores the clear bit
  property p_mode_write;
    @(posedge mclk) disable iff (localRst)
      modeWrite |=> modeValue == {1'b0, $past(modeWrData[SEL_MSB:SEL_LSB])} && !modeValue[CLR_BIT];
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode write mismatch");

  // Watchdog overflow gives a single reset pulse
  property p_wd_reset;
    @(posedge mclk) disable iff (rst)
      overflow && lockReg && inRun && !intResetReg |=> internalReset ##1 !internalReset;
  endproperty
  a_wd_reset: assert property (p_wd_reset) else $error("watchdog reset missing");

  // No reset from overflow during a wait
  property p_wait_mask;
    @(posedge mclk) disable iff (rst)
      overflow && !inRun |=> !internalReset;
  endproperty
  a_wait_mask: assert property (p_wait_mask) else $error("reset during wait");

  // Lock holds until a reset
  property p_lock_hold;
    @(posedge mclk) disable iff (localRst)
      watchdogSelect |=> watchdogSelect;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock cleared by software");

  // Halt holds through the stop wait until overflow
  property p_halt_wait;
    @(posedge mclk) disable iff (localRst)
      stateReg == ST_STOP_WAIT && !overflow |=> cpuHalt;
  endproperty
  a_halt_wait: assert property (p_halt_wait) else $error("halt dropped early");

  // Reset returns the longest interval
  property p_mode_reset;
    @(posedge mclk) rst |=> modeValue == MODE_RESET && cpuHalt;
  endproperty
  a_mode_reset: assert property (p_mode_reset) else $error("mode not cleared by reset");

  // Reset wait runs on the build-time tap, whatever the mode register says
  property p_reset_wait_tap;
    @(posedge mclk) disable iff (localRst)
      stateReg == ST_RESET_WAIT |-> tk.tapSel == RESET_WAIT_SEL;
  endproperty
  a_reset_wait_tap: assert property (p_reset_wait_tap) else $error("reset wait on wrong tap");

  // Cleared mode register means the longest interval
  property p_default_tap;
    @(posedge mclk) disable iff (localRst)
      stateReg != ST_RESET_WAIT && modeValue == MODE_RESET |-> tk.tapSel == TAP_IDX_LONG;
  endproperty
  a_default_tap: assert property (p_default_tap) else $error("reset mode not longest interval");

  // Overflow ends the reset wait and frees the CPU
  property p_reset_wait_end;
    @(posedge mclk) disable iff (localRst)
      stateReg == ST_RESET_WAIT && overflow |=> !cpuHalt;
  endproperty
  a_reset_wait_end: assert property (p_reset_wait_end) else $error("reset wait did not end");

  // Overflow ends the stop wait and frees the CPU
  property p_wake;
    @(posedge mclk) disable iff (localRst)
      stateReg == ST_STOP_WAIT && overflow |=> !cpuHalt && inRun;
  endproperty
  a_wake: assert property (p_wake) else $error("stop wait did not end");

  // Stop request in run halts the CPU at once
  property p_stop_enter;
    @(posedge mclk) disable iff (localRst)
      inRun && stopEnter |=> cpuHalt && stateReg == ST_STOP;
  endproperty
  a_stop_enter: assert property (p_stop_enter) else $error("stop not entered");

  // Release starts the wait from a cleared count
  property p_stop_release;
    @(posedge mclk) disable iff (localRst)
      stateReg == ST_STOP && stopRelease |=> stateReg == ST_STOP_WAIT && counterValue == CNT_ZERO && cpuHalt;
  endproperty
  a_stop_release: assert property (p_stop_release) else $error("stop wait not started");

  // Flag is sticky until a clear
  property p_irq_hold;
    @(posedge mclk) disable iff (localRst)
      irqFlag && !clearStrobe && !irqFlagClear |=> irqFlag;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("flag dropped without clear");

  // Overflow outside run never raises the flag
  property p_wait_no_irq;
    @(posedge mclk) disable iff (localRst)
      overflow && !inRun && !irqFlag |=> !irqFlag;
  endproperty
  a_wait_no_irq: assert property (p_wait_no_irq) else $error("flag set during wait");

  // Lock request always lands
  property p_lock_set;
    @(posedge mclk) disable iff (localRst)
      wdSelectSet |=> watchdogSelect;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock not set");

  // Watchdog overflow resets instead of interrupting
  property p_wd_no_irq;
    @(posedge mclk) disable iff (rst)
      overflow && lockReg && inRun && !irqFlag |=> !irqFlag;
  endproperty
  a_wd_no_irq: assert property (p_wd_no_irq) else $error("flag set in watchdog mode");

  // Main scenarios
  c_irq: cover property (@(posedge mclk) disable iff (localRst) overflow && inRun && !lockReg);
  c_wd_reset: cover property (@(posedge mclk) disable iff (rst) internalReset);
  c_stop_wake: cover property (@(posedge mclk) disable iff (localRst) stateReg == ST_STOP_WAIT ##1 !cpuHalt);
  c_kick: cover property (@(posedge mclk) disable iff (localRst) clearStrobe && lockReg);

endmodule // iwdt_interval_watchdog

//--- iwdt_interval_watchdog_tb.sv
`timescale 1ns/1ps
module iwdt_interval_watchdog_tb;
  import iwdt_pkg::*;
  // Shortest tap for the reset wait keeps the run short
  localparam logic [1:0] WAIT_SEL = 2'h3;
  localparam int SLACK = 2 ** TAP_SHORT;
  localparam int OVF = 256 * SLACK;
  localparam int LO = OVF - 2 * SLACK;
  localparam int HI = OVF + SLACK;
  localparam int O_MODE = 0, O_CNT = 1, O_LOCK = 2, O_IRQ = 3, O_HALT = 4, O_IRST = 5;
  typedef struct { int sel; logic [7:0] val; } iwdt_note_t;

  logic mclk, rst, modeWrite, wdSelectSet, irqFlagClear, stopEnter, stopRelease;
  logic [MODE_W-1:0] modeWrData, modeValue;
  logic [CNT_W-1:0] counterValue, c0, diff;
  logic watchdogSelect, irqFlag, internalReset, cpuHalt;
  logic irstSeen = 1'b0;
  logic [31:0] rnd;
  iwdt_note_t noteQ[$];
  int bad_count = 0;
  int comparisons = 0;
  int seed = 32'h898A5054;
  int elapsed;

  iwdt_interval_watchdog #(.RESET_WAIT_SEL(WAIT_SEL)) dut (.mclk(mclk), .rst(rst), .modeWrite(modeWrite),
    .modeWrData(modeWrData), .wdSelectSet(wdSelectSet), .irqFlagClear(irqFlagClear), .stopEnter(stopEnter),
    .stopRelease(stopRelease), .modeValue(modeValue), .counterValue(counterValue),
    .watchdogSelect(watchdogSelect), .irqFlag(irqFlag), .internalReset(internalReset), .cpuHalt(cpuHalt));

  // Free-running 10 MHz clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Output picked by a note selector
  function automatic logic [7:0] outVal(input int sel);
    case (sel)
      O_MODE: outVal = {4'h0, modeValue};
      O_CNT: outVal = counterValue;
      O_LOCK: outVal = {7'h00, watchdogSelect};
      O_IRQ: outVal = {7'h00, irqFlag};
      O_HALT: outVal = {7'h00, cpuHalt};
      default: outVal = {7'h00, internalReset};
    endcase
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic checkRange(input int n, input string what);
    check({31'h0, (n >= LO && n <= HI)}, 32'h1, what);
  endtask

  // Expected value of an output just after the coming rising edge
  task automatic note(input int sel, input logic [7:0] val);
    noteQ.push_back('{sel, val});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Counter read twice; a pair that disagrees is read again
  task automatic readCnt(output logic [7:0] v);
    v = counterValue;
    cyc(1);
    while (counterValue !== v) begin
      v = counterValue;
      cyc(1);
    end
  endtask

  task automatic writeMode(input logic [3:0] d, input logic clr);
    modeWrite = 1'b1;
    modeWrData = d;
    note(O_MODE, {5'h00, d[2:0]});
    if (clr) begin
      note(O_CNT, 8'h00);
      note(O_IRQ, 8'h00);
    end
    cyc(1);
    modeWrite = 1'b0;
    cyc(1); // Idle edge so back-to-back calls never re-raise the strobe at once
  endtask

  // Bounded wait on an output, counted in clocks
  task automatic waitFor(input int sel, input logic [7:0] val, output int n);
    n = 0;
    while (outVal(sel) !== val && n < OVF + 4 * SLACK) begin
      cyc(1);
      n++;
    end
  endtask

  task automatic summarize;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Checker: drains notes once the edge's updates have landed
  initial begin : monitor
    iwdt_note_t n;
    forever begin
      @(posedge mclk);
      #10;
      while (noteQ.size() > 0) begin
        n = noteQ.pop_front();
        check({24'h0, outVal(n.sel)}, {24'h0, n.val}, "output");
      end
    end
  end

  // Sticky record of any watchdog reset pulse
  always @(posedge mclk) begin
    if (internalReset === 1'b1) irstSeen <= 1'b1;
  end

  // Hang guard, generous against the planned run
  initial begin
    #(100000 * 100);
    bad_count++;
    $display("BAD at %0t: watchdog expired", $time);
    summarize();
  end

  initial begin : main
    {modeWrite, wdSelectSet, irqFlagClear, stopEnter, stopRelease} = 5'h00;
    modeWrData = 4'h0;
    rst = 1'b1;
    cyc(4);
    rst = 1'b0;
    note(O_MODE, 8'h00);
    note(O_LOCK, 8'h00);
    note(O_HALT, 8'h01);
    waitFor(O_HALT, 8'h00, elapsed);
    checkRange(elapsed, "reset wait");
    note(O_IRQ, 8'h00);
    $display("test reset wait done");
    // Random writes; a set bit 3 also clears counter and flag
    for (int i = 0; i < 8; i++) begin
      rnd = $random(seed);
      writeMode(rnd[3:0], rnd[3]);
    end
    // Shortest tap, so a 128-cycle window holds exactly four ticks
    writeMode(4'h7, 1'b0);
    readCnt(c0);
    cyc(4 * SLACK - 1);
    readCnt(diff);
    diff = diff - c0;
    check({24'h0, diff}, 32'h4, "count rate");
    $display("test mode field done");
    // Interval mode: start, overflow, acknowledge
    writeMode(4'hF, 1'b1);
    waitFor(O_IRQ, 8'h01, elapsed);
    checkRange(elapsed, "interval");
    writeMode(4'hF, 1'b1);
    waitFor(O_IRQ, 8'h01, elapsed);
    checkRange(elapsed, "interval again");
    irqFlagClear = 1'b1;
    note(O_IRQ, 8'h00);
    cyc(1);
    irqFlagClear = 1'b0;
    check({31'h0, irstSeen}, 32'h0, "no reset in interval mode");
    $display("test interval done");
    // Lock, then stop and wake with the programmed interval
    wdSelectSet = 1'b1;
    note(O_LOCK, 8'h01);
    cyc(1);
    wdSelectSet = 1'b0;
    writeMode(4'hF, 1'b1);
    stopEnter = 1'b1;
    note(O_HALT, 8'h01);
    cyc(1);
    stopEnter = 1'b0;
    cyc(20);
    stopRelease = 1'b1;
    note(O_CNT, 8'h00);
    cyc(1);
    stopRelease = 1'b0;
    waitFor(O_HALT, 8'h00, elapsed);
    checkRange(elapsed, "stop wait");
    check({31'h0, irstSeen}, 32'h0, "reset during wait");
    $display("test stop wait done");
    // Kicks in time hold off the watchdog
    for (int k = 0; k < 3; k++) begin
      cyc(OVF / 2);
      writeMode(4'hF, 1'b1);
      note(O_LOCK, 8'h01);
    end
    check({31'h0, irstSeen}, 32'h0, "reset despite kicks");
    waitFor(O_IRST, 8'h01, elapsed);
    checkRange(elapsed, "watchdog overflow");
    note(O_IRST, 8'h00);
    note(O_IRQ, 8'h00);
    note(O_HALT, 8'h01);
    note(O_MODE, 8'h00);
    note(O_LOCK, 8'h00);
    cyc(1);
    $display("test watchdog done");
    // External reset drops a set lock
    waitFor(O_HALT, 8'h00, elapsed);
    checkRange(elapsed, "wait after watchdog reset");
    wdSelectSet = 1'b1;
    note(O_LOCK, 8'h01);
    cyc(1);
    wdSelectSet = 1'b0;
    rst = 1'b1;
    note(O_LOCK, 8'h00);
    note(O_HALT, 8'h01);
    cyc(2);
    rst = 1'b0;
    cyc(2);
    $display("test lock reset done");
    summarize();
  end
endmodule // iwdt_interval_watchdog_tb
